/* design/dgp_pkg.sv */
package dgp_pkg;
  // System clock and the internal switching oscillator it stands in for
  localparam int CLK_HZ = 200_000_000;
  localparam int OSC_HZ = 8_000_000;
  // System clocks per oscillator edge (25 at 200 MHz)
  localparam int TICK_DIV = CLK_HZ / OSC_HZ;
  // Legal switching divisor range
  localparam int N_MIN = 4;
  localparam int N_MAX = 256;
  // Divisor floor as a register value (register holds N - 1)
  localparam logic [7:0] PERIOD_FLOOR = 8'(N_MIN - 1);

  // Register offsets
  localparam logic [3:0] ADDR_PERIOD = 4'h0;
  localparam logic [3:0] ADDR_DUTY = 4'h1;
  localparam logic [3:0] ADDR_DEAD = 4'h2;
  localparam logic [3:0] ADDR_DRV_EN = 4'h3;
  localparam logic [3:0] ADDR_ABLK_EN = 4'h4;
  localparam logic [3:0] ADDR_FLAGS = 4'h5;
  localparam logic [3:0] ADDR_MASK = 4'h6;
  localparam logic [3:0] ADDR_STATUS = 4'h7;
  localparam logic [3:0] ADDR_ATEST = 4'h8;

  // Reset values
  localparam logic [7:0] RST_PERIOD = 8'hff;
  localparam logic [7:0] RST_DUTY = 8'h80;
  localparam logic [7:0] RST_DEAD = 8'h04;
  localparam logic [1:0] RST_DRV_EN = 2'h0;
  localparam logic RST_VAMP_DIS = 1'b0;
  localparam logic [1:0] RST_FLAGS = 2'h0;
  localparam logic [1:0] RST_MASK = 2'h0;
  localparam logic [2:0] RST_ATEST = 3'h0;

  // Field positions
  localparam int BIT_EN_PRI = 0;
  localparam int BIT_EN_SEC = 1;
  localparam int BIT_VAMP_DIS = 0;
  localparam int BIT_OVERTEMP = 0;
  localparam int BIT_OVERVOLT = 1;
  localparam int ATEST_W = 3;
  // Test mux code that selects the second temperature monitor
  localparam logic [2:0] ATEST_TEMP_MON = 3'h1;

  // Switching sequence states
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_DEAD_P,
    ST_PRI_ON,
    ST_DEAD_S,
    ST_SEC_ON
  } dgp_state_type;
endpackage

/* design/dgp_sync.sv */
`timescale 1ns/1ps
module dgp_sync #(
  parameter int W = 4
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);
  // Two-stage synchroniser per bit; stage one feeds stage two only
  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_bit
      logic meta_ff;
      logic sync_ff;
      always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
          meta_ff <= 1'b0;
          sync_ff <= 1'b0;
        end else begin
          meta_ff <= async_in[i];
          sync_ff <= meta_ff;
        end
      end
      assign sync_out[i] = sync_ff;
    end
  endgenerate
endmodule // dgp_sync

/* design/dgp_pwm_top.sv */
// Function
// - Period counted in whole 8 MHz edges
// - Frequency is 8 MHz over N, 4..256
// - Primary on-time capped by duty limit
// - Cycle start from period only, not comparator
// - Reference to voltage amplifier by default
// - Disable bit routes reference to OV comparator
// - Overvoltage comparator raises interrupt request
// - Each drive gated by own enable
// - Programmable dead time, drives never overlap
// - Over-temperature forces both drives off
// - Entering shutdown sets overtemp flag
// - Resume only after cooling to 130 C
// - Temperature monitor selectable on test mux
// - Current trip latches primary off until cycle
// - Dead time before secondary goes high
`timescale 1ns/1ps
module dgp_pwm_top
  import dgp_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic [3:0] addr,
  input wire logic [7:0] wr_data,
  input wire logic wr_stb,
  input wire logic rd_stb,
  output logic [7:0] rd_data,
  input wire logic current_trip_in,
  input wire logic ov_cmp_in,
  input wire logic temp_hot_in,
  input wire logic temp_cool_in,
  output logic primary_gate_drive,
  output logic secondary_gate_drive,
  output logic ref_to_vamp,
  output logic ref_to_ovcmp,
  output logic [ATEST_W-1:0] atest_mux_sel,
  output logic irq
);
  // Width of the oscillator edge divider
  // (one count per system clock, wrapping once per oscillator period)
  localparam int TW = $clog2(TICK_DIV);
  localparam logic [TW-1:0] TICK_LAST = TW'(TICK_DIV - 1);

  // Synchronised pins
  // Analog-side pins, so each passes two flops before use
  logic [3:0] pins_sync;
  logic trip_s;
  logic ov_s;
  logic hot_s;
  logic cool_s;

  // Software registers
  // All come out of reset at the package values
  logic [7:0] period_ff;
  logic [7:0] duty_ff;
  logic [7:0] dead_time_ff;
  logic [1:0] drv_en_ff;
  logic vamp_dis_ff;
  logic [1:0] flags_ff;
  logic [1:0] mask_ff;
  logic [ATEST_W-1:0] atest_ff;

  // Timing state
  // Everything counts system clocks except the period count
  logic [TW-1:0] tick_cnt_ff;
  logic [7:0] per_cnt_ff;
  logic [7:0] dead_cnt_ff;
  dgp_state_type state_ff;
  dgp_state_type nxt_state;
  logic shutdown_ff;
  logic ov_prev_ff;
  logic pri_ff;
  logic sec_ff;
  logic [7:0] rd_data_ff;

  // Decoded strobes
  // Unmapped offsets decode to nothing, so such writes are dropped
  wire wr_period = wr_stb && (addr == ADDR_PERIOD);
  wire wr_duty = wr_stb && (addr == ADDR_DUTY);
  wire wr_dead = wr_stb && (addr == ADDR_DEAD);
  wire wr_drv_en = wr_stb && (addr == ADDR_DRV_EN);
  wire wr_ablk = wr_stb && (addr == ADDR_ABLK_EN);
  wire wr_flags = wr_stb && (addr == ADDR_FLAGS);
  wire wr_mask = wr_stb && (addr == ADDR_MASK);
  wire wr_atest = wr_stb && (addr == ADDR_ATEST);

  // Pin synchronisers, two flops each before any logic
  dgp_sync #(
    .W(4)
  ) u_sync (
    .clk_sys(clk_sys),
    .rst(rst),
    .async_in({temp_cool_in, temp_hot_in, ov_cmp_in, current_trip_in}),
    .sync_out(pins_sync)
  );
  assign trip_s = pins_sync[0];
  assign ov_s = pins_sync[1];
  assign hot_s = pins_sync[2];
  assign cool_s = pins_sync[3];

  // Oscillator edge: one pulse per 8 MHz period, a single edge only
  // Every switching period is a whole number of these pulses
  wire osc_tick = (tick_cnt_ff == TICK_LAST);

  // Effective divisor, clamped so N never drops below its floor
  // Register values 0..2 would ask for N below 4, which the grid
  // cannot give; they read back as written but run as 3
  wire [7:0] n_last = (period_ff < PERIOD_FLOOR) ? PERIOD_FLOOR : period_ff;

  // Cycle start comes from the period counter alone; the
  // magnetic-drain comparator has no path into it here
  // Quasi-resonant restart is not built: fixed frequency only
  wire cycle_start = osc_tick && (per_cnt_ff == n_last);

  // Primary ends on a current trip or at the duty cap
  // Duty counts from cycle start, leading dead time included, so a
  // limit of zero still lets the primary on for one clock
  wire duty_reached = (per_cnt_ff >= duty_ff);
  wire pri_stop = trip_s || duty_reached;

  // Dead-time counter exhausted
  wire dead_done = (dead_cnt_ff == 8'h00);

  // Overvoltage edge, counted only while the comparator owns the reference
  // While the amplifier owns the reference the comparator is idle
  wire ov_event = ov_s && !ov_prev_ff && vamp_dis_ff;

  // Shutdown entry edge
  wire ot_event = hot_s && !shutdown_ff;

  // Write-one-to-clear requests per flag
  wire clr_overtemp = wr_flags && wr_data[BIT_OVERTEMP];
  wire clr_overvolt = wr_flags && wr_data[BIT_OVERVOLT];

  // Oscillator edge divider
  // Free-running, so a new period starts on the existing grid
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      tick_cnt_ff <= '0;
    end else if (osc_tick) begin
      tick_cnt_ff <= '0;
    end else begin
      tick_cnt_ff <= tick_cnt_ff + TW'(1);
    end
  end

  // Period counter in whole oscillator periods
  // Shortening the period mid-count lets this run on to 255 and wrap,
  // so one long period can follow such a write
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      per_cnt_ff <= 8'h00;
    end else if (cycle_start) begin
      per_cnt_ff <= 8'h00;
    end else if (osc_tick) begin
      per_cnt_ff <= per_cnt_ff + 8'h01;
    end
  end

  // Sequence: dead, primary, dead, secondary, repeat each period.
  // Leaving the primary state before the next start acts as the
  // set-reset latch that keeps the switch off for the rest of the cycle.
  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      ST_IDLE: begin
        if (cycle_start) begin
          nxt_state = ST_DEAD_P;
        end
      end
      ST_DEAD_P: begin
        // Secondary already off; wait before primary turns on
        if (dead_done) begin
          nxt_state = ST_PRI_ON;
        end
      end
      ST_PRI_ON: begin
        if (cycle_start) begin
          nxt_state = ST_DEAD_P;
        end else if (pri_stop) begin
          nxt_state = ST_DEAD_S;
        end
      end
      ST_DEAD_S: begin
        // Primary off; hold secondary off for the dead time
        if (cycle_start) begin
          nxt_state = ST_DEAD_P;
        end else if (dead_done) begin
          nxt_state = ST_SEC_ON;
        end
      end
      ST_SEC_ON: begin
        if (cycle_start) begin
          nxt_state = ST_DEAD_P;
        end
      end
      // Unused codes fall back to idle and wait for a period start
      default: begin
        nxt_state = ST_IDLE;
      end
    endcase
    // Thermal shutdown overrides everything
    if (shutdown_ff) begin
      nxt_state = ST_IDLE;
    end
  end

  // State register
  // Shutdown forces idle through the next-state logic, not here
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      state_ff <= ST_IDLE;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // Dead-time counter, reloaded on every state change
  // A setting of zero still leaves one idle clock between drives
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      dead_cnt_ff <= 8'h00;
    end else if (nxt_state != state_ff) begin
      dead_cnt_ff <= dead_time_ff;
    end else if (!dead_done) begin
      dead_cnt_ff <= dead_cnt_ff - 8'h01;
    end
  end

  // Thermal latch: set at the hot limit, cleared only once cool.
  // Hot wins if both inputs ever read high together.
  // Cool alone never restarts a drive mid-period: the sequence waits
  // in idle for the next period start
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      shutdown_ff <= 1'b0;
    end else if (hot_s) begin
      shutdown_ff <= 1'b1;
    end else if (cool_s) begin
      shutdown_ff <= 1'b0;
    end
  end

  // Drive outputs; both states registered alike so spacing holds
  // Built from the next state so the pins are flops without a cycle
  // of lag; an enable set mid-phase takes effect at once
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      pri_ff <= 1'b0;
      sec_ff <= 1'b0;
    end else begin
      pri_ff <= (nxt_state == ST_PRI_ON) && drv_en_ff[BIT_EN_PRI];
      sec_ff <= (nxt_state == ST_SEC_ON) && drv_en_ff[BIT_EN_SEC];
    end
  end
  assign primary_gate_drive = pri_ff;
  assign secondary_gate_drive = sec_ff;

  // Reference steering follows the voltage amplifier disable bit
  assign ref_to_vamp = !vamp_dis_ff;
  assign ref_to_ovcmp = vamp_dis_ff;

  // Test mux select; ATEST_TEMP_MON routes the temperature monitor
  // Other codes pass through for the mux's other inputs
  assign atest_mux_sel = atest_ff;

  // Configuration registers
  // Bits above each field are ignored on write
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      period_ff <= RST_PERIOD;
      duty_ff <= RST_DUTY;
      dead_time_ff <= RST_DEAD;
      drv_en_ff <= RST_DRV_EN;
      vamp_dis_ff <= RST_VAMP_DIS;
      mask_ff <= RST_MASK;
      atest_ff <= RST_ATEST;
    end else begin
      if (wr_period) begin
        period_ff <= wr_data;
      end
      if (wr_duty) begin
        duty_ff <= wr_data;
      end
      if (wr_dead) begin
        dead_time_ff <= wr_data;
      end
      if (wr_drv_en) begin
        drv_en_ff <= wr_data[1:0];
      end
      if (wr_ablk) begin
        vamp_dis_ff <= wr_data[BIT_VAMP_DIS];
      end
      if (wr_mask) begin
        mask_ff <= wr_data[1:0];
      end
      if (wr_atest) begin
        atest_ff <= wr_data[ATEST_W-1:0];
      end
    end
  end

  // Sticky flags: write one to clear; a new event beats the clear
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      flags_ff <= RST_FLAGS;
      ov_prev_ff <= 1'b0;
    end else begin
      ov_prev_ff <= ov_s;
      flags_ff[BIT_OVERTEMP] <= ot_event || (flags_ff[BIT_OVERTEMP] && !clr_overtemp);
      flags_ff[BIT_OVERVOLT] <= ov_event || (flags_ff[BIT_OVERVOLT] && !clr_overvolt);
    end
  end

  // Level interrupt while any unmasked flag is set
  // Masking hides a flag from the line but never clears it
  assign irq = |(flags_ff & mask_ff);

  // Live status word
  // Shutdown, primary, secondary, then the two synchronised pins
  wire [7:0] status_word = {3'h0, hot_s, ov_s, sec_ff, pri_ff, shutdown_ff};

  // Read selection; unmapped offsets read as zero
  wire [7:0] rd_mux =
    (addr == ADDR_PERIOD) ? period_ff :
    (addr == ADDR_DUTY) ? duty_ff :
    (addr == ADDR_DEAD) ? dead_time_ff :
    (addr == ADDR_DRV_EN) ? {6'h00, drv_en_ff} :
    (addr == ADDR_ABLK_EN) ? {7'h00, vamp_dis_ff} :
    (addr == ADDR_FLAGS) ? {6'h00, flags_ff} :
    (addr == ADDR_MASK) ? {6'h00, mask_ff} :
    (addr == ADDR_STATUS) ? status_word :
    (addr == ADDR_ATEST) ? {5'h00, atest_ff} : 8'h00;

  // Read data valid for one cycle after the strobe, zero otherwise
  // Zero outside the answer cycle so a stale value is never seen
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      rd_data_ff <= 8'h00;
    end else if (rd_stb) begin
      rd_data_ff <= rd_mux;
    end else begin
      rd_data_ff <= 8'h00;
    end
  end
  assign rd_data = rd_data_ff;
endmodule // dgp_pwm_top

/* bench/dgp_pwm_chk.sv */
`timescale 1ns/1ps
module dgp_pwm_chk
  import dgp_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic current_trip_in,
  input wire logic temp_hot_in,
  input wire logic primary_gate_drive,
  input wire logic secondary_gate_drive,
  input wire logic ref_to_vamp,
  input wire logic ref_to_ovcmp
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  logic pri_q_ff; // Primary one cycle late
  logic seen_ff; // A first rise has been seen
  logic [16:0] gap_ff; // Cycles since last primary rise
  wire pri_rise = primary_gate_drive && !pri_q_ff;
  wire drive_on = primary_gate_drive || secondary_gate_drive; // Either gate on
  // Rise spacing; the first rise after reset has no reference
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      pri_q_ff <= 1'b0;
      seen_ff <= 1'b0;
      gap_ff <= 17'h0;
    end else begin
      pri_q_ff <= primary_gate_drive;
      seen_ff <= seen_ff | pri_rise;
      gap_ff <= pri_rise ? 17'h1 : gap_ff + 17'h1;
    end
  end
  // Dead gaps, five cycles at the dead time kept by the bench
  sequence pri_quiet; !primary_gate_drive [*5]; endsequence
  sequence sec_quiet; !secondary_gate_drive [*5]; endsequence
  // A cut primary stays off well past one dead time
  sequence pri_off_long; !primary_gate_drive [*8]; endsequence
  a_drives_exclusive: assert property (!(primary_gate_drive && secondary_gate_drive))
    else $error("both gate drives high");
  a_ref_route: assert property (ref_to_vamp != ref_to_ovcmp)
    else $error("reference routed to both or neither");
  a_pri_sec_gap: assert property ($fell(primary_gate_drive) |-> sec_quiet)
    else $error("secondary rose inside dead time");
  a_sec_pri_gap: assert property ($fell(secondary_gate_drive) |-> pri_quiet)
    else $error("primary rose inside dead time");
  a_pri_latched: assert property ($fell(primary_gate_drive) |-> pri_off_long)
    else $error("primary restarted in same cycle");
  a_trip_cut: assert property (current_trip_in [*3] |-> ##2 !primary_gate_drive)
    else $error("current trip did not end on-time");
  a_hot_off: assert property (temp_hot_in [*3] |-> ##2 !drive_on)
    else $error("drive on during thermal shutdown");
  a_tick_grid: assert property (pri_rise && seen_ff |-> gap_ff % TICK_DIV == 0)
    else $error("cycle start off the oscillator grid");
endmodule // dgp_pwm_chk

bind dgp_pwm_top dgp_pwm_chk dgp_pwm_chk_inst (.clk_sys(clk_sys), .rst(rst),
  .current_trip_in(current_trip_in), .temp_hot_in(temp_hot_in),
  .primary_gate_drive(primary_gate_drive), .secondary_gate_drive(secondary_gate_drive),
  .ref_to_vamp(ref_to_vamp), .ref_to_ovcmp(ref_to_ovcmp));

/* bench/dgp_gate_model.sv */
`timescale 1ns/1ps
module dgp_gate_model (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic primary_gate_drive,
  input wire logic trip_en,
  input wire logic [7:0] trip_at,
  output logic current_trip_in
);
  logic [7:0] ramp; // Primary current ramp, in cycles of on-time
  // Current builds only while the primary switch conducts
  always @(posedge clk_sys or posedge rst) begin
    if (rst || !primary_gate_drive) begin
      ramp <= 8'h0;
      current_trip_in <= 1'b0;
    end else begin
      ramp <= ramp + 8'h1;
      current_trip_in <= trip_en && (ramp >= trip_at);
    end
  end
endmodule // dgp_gate_model

/* bench/testbench.sv */
`timescale 1ns/1ps
module testbench
  import dgp_pkg::*;
;
  logic clk_sys = 0, rst = 1, wr_stb = 0, rd_stb = 0, ov_cmp_in = 0;
  logic temp_hot_in = 0, temp_cool_in = 0, trip_en = 0, current_trip_in;
  logic [3:0] addr = 4'h0;
  logic [7:0] wr_data = 8'h0, rd_data, d;
  logic primary_gate_drive, secondary_gate_drive, ref_to_vamp, ref_to_ovcmp, irq, sp, ss;
  logic [ATEST_W-1:0] atest_mux_sel;
  int fail_count = 0, comparisons = 0, cyc = 0, per, wid;
  typedef struct {logic w; logic [3:0] a; logic [7:0] d; logic [7:0] e;} dgp_row_type;
  // Reset values first, then writes read back; a short period reads back raw
  dgp_row_type rows[17] = '{'{1'b0, 4'h0, 8'h00, 8'hff}, '{1'b0, 4'h1, 8'h00, 8'h80},
    '{1'b0, 4'h2, 8'h00, 8'h04}, '{1'b0, 4'h3, 8'h00, 8'h00}, '{1'b0, 4'h4, 8'h00, 8'h00},
    '{1'b0, 4'h5, 8'h00, 8'h00}, '{1'b0, 4'h6, 8'h00, 8'h00}, '{1'b0, 4'h8, 8'h00, 8'h00},
    '{1'b0, 4'h9, 8'h00, 8'h00}, '{1'b1, 4'h0, 8'h01, 8'h01}, '{1'b1, 4'h0, 8'h03, 8'h03},
    '{1'b1, 4'h4, 8'hfe, 8'h00}, '{1'b1, 4'h8, 8'h01, 8'h01}, '{1'b1, 4'h9, 8'h55, 8'h00},
    '{1'b1, 4'h2, 8'h04, 8'h04}, '{1'b1, 4'h1, 8'h02, 8'h02}, '{1'b1, 4'h3, 8'h02, 8'h02}};
  dgp_pwm_top dgp_pwm_top_inst (.clk_sys(clk_sys), .rst(rst), .addr(addr),
    .wr_data(wr_data), .wr_stb(wr_stb), .rd_stb(rd_stb), .rd_data(rd_data),
    .current_trip_in(current_trip_in), .ov_cmp_in(ov_cmp_in), .temp_hot_in(temp_hot_in),
    .temp_cool_in(temp_cool_in), .primary_gate_drive(primary_gate_drive),
    .secondary_gate_drive(secondary_gate_drive), .ref_to_vamp(ref_to_vamp),
    .ref_to_ovcmp(ref_to_ovcmp), .atest_mux_sel(atest_mux_sel), .irq(irq));
  dgp_gate_model dgp_gate_model_inst (.clk_sys(clk_sys), .rst(rst),
    .primary_gate_drive(primary_gate_drive), .trip_en(trip_en), .trip_at(8'h0a),
    .current_trip_in(current_trip_in));
  initial begin
    forever #2.5 clk_sys = ~clk_sys;
  end
  // Hang guard, well past the longest sequence
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 80000) begin
      fail_count++;
      report_and_stop();
    end
  end
  task chk(input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fail_count++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // One-cycle strobes, changed just after the edge
  task wr(input logic [3:0] a, input logic [7:0] v);
    @(posedge clk_sys);
    addr <= a;
    wr_data <= v;
    wr_stb <= 1'b1;
    @(posedge clk_sys);
    wr_stb <= 1'b0;
    #1;
  endtask
  task rd(input logic [3:0] a);
    @(posedge clk_sys);
    addr <= a;
    rd_stb <= 1'b1;
    @(posedge clk_sys);
    rd_stb <= 1'b0;
    @(negedge clk_sys);
    d = rd_data;
  endtask
  // OR of both drives over k cycles
  task watch(input int k);
    sp = 0;
    ss = 0;
    repeat (k) begin
      @(posedge clk_sys);
      #1;
      sp = sp | primary_gate_drive;
      ss = ss | secondary_gate_drive;
    end
  endtask
  // Period and on-width of one primary pulse, bounded
  task meas();
    int n;
    logic p;
    n = 0;
    p = 1;
    per = 0;
    wid = 0;
    while (!(primary_gate_drive === 1 && p === 0) && n < 15000) begin
      p = primary_gate_drive;
      @(posedge clk_sys);
      #1;
      n++;
    end
    do begin
      wid += (primary_gate_drive === 1);
      per++;
      p = primary_gate_drive;
      @(posedge clk_sys);
      #1;
    end while (!(primary_gate_drive === 1 && p === 0) && per < 15000);
  endtask
  task ov_pulse();
    ov_cmp_in <= 1'b1;
    repeat (4) @(posedge clk_sys);
    ov_cmp_in <= 1'b0;
    repeat (4) @(posedge clk_sys);
    #1;
  endtask
  task report_and_stop();
    $display("comparisons %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    repeat (12) @(posedge clk_sys);
    rst <= 1'b0;
    foreach (rows[i]) begin
      if (rows[i].w) wr(rows[i].a, rows[i].d);
      rd(rows[i].a);
      chk(d, rows[i].e);
    end
    chk(atest_mux_sel, ATEST_TEMP_MON);
    $display("register table done");
    // Enable the primary inside the secondary phase so its rises stay on the grid
    @(posedge secondary_gate_drive);
    wr(ADDR_DRV_EN, 8'h03);
    meas();
    meas();
    chk(per, N_MIN * TICK_DIV);
    chk(wid < 2 * TICK_DIV, 1);
    wr(ADDR_PERIOD, 8'hff);
    meas();
    meas();
    chk(per, N_MAX * TICK_DIV);
    // A value below the floor must run as the shortest period
    wr(ADDR_PERIOD, 8'h01);
    trip_en <= 1'b1;
    meas();
    meas();
    chk(per, N_MIN * TICK_DIV);
    chk(wid >= 10 && wid <= 15, 1);
    trip_en <= 1'b0;
    $display("period and duty done");
    wr(ADDR_DRV_EN, 8'h01);
    watch(300);
    chk({sp, ss}, 2'h2);
    wr(ADDR_DRV_EN, 8'h02);
    watch(300);
    chk({sp, ss}, 2'h1);
    @(posedge secondary_gate_drive);
    wr(ADDR_DRV_EN, 8'h03);
    $display("enables done");
    chk(ref_to_vamp, 1);
    wr(ADDR_MASK, 8'h02);
    ov_pulse();
    chk(irq, 0);
    wr(ADDR_ABLK_EN, 8'h01);
    chk({ref_to_vamp, ref_to_ovcmp}, 2'h1);
    ov_pulse();
    chk(irq, 1);
    rd(ADDR_FLAGS);
    chk(d, 8'h02);
    wr(ADDR_MASK, 8'h00);
    chk(irq, 0);
    wr(ADDR_MASK, 8'h03);
    wr(ADDR_FLAGS, 8'h02);
    chk(irq, 0);
    $display("overvoltage done");
    temp_hot_in <= 1'b1;
    watch(6);
    watch(300);
    chk(sp | ss, 0);
    chk(irq, 1);
    rd(ADDR_FLAGS);
    chk(d, 8'h01);
    rd(ADDR_STATUS);
    chk(d[0], 1);
    temp_hot_in <= 1'b0;
    watch(300);
    chk(sp | ss, 0);
    temp_cool_in <= 1'b1;
    watch(300);
    chk({sp, ss}, 2'h3);
    temp_cool_in <= 1'b0;
    $display("thermal done");
    @(posedge clk_sys);
    rst <= 1'b1;
    #1;
    chk({primary_gate_drive, secondary_gate_drive}, 2'h0);
    repeat (12) @(posedge clk_sys);
    rst <= 1'b0;
    rd(ADDR_DRV_EN);
    chk(d, RST_DRV_EN);
    $display("mid-run reset done");
    report_and_stop();
  end
endmodule // testbench
